// file: lgp_pkg.sv
// Constants and carrier types for the ten-port GPIO / LED sink control block.
// Assumes a single 100 MHz clock domain; pins and the PWM clock arrive asynchronously.
//
// Functional notes
// - Ten independent ports, each logic input, open-drain output or current sink.
// - Code 0x02 gives a static constant-current sink while running, no PWM.
// - Codes 0x03 to 0xFE give PWM sink, duty equal to code over 256.
// - Code 0xFF leaves the port high impedance, running or in shutdown.
// - Each current port has a per-port full/half (20mA/10mA) select in logic.
// - After power-up every port is high impedance and draws nothing.
// - Standby with PWM idle when every code is 0x00, 0x01 or 0xFF.
// - PWM circuitry runs whenever any port code lies in 0x03 to 0xFE.
// - Per-port mirror enable only while sinking; PWM ports only in on-time.
// - In shutdown, codes 0x02 to 0xFE go high impedance like 0xFF.
// - Codes 0x00 and 0x01 act the same in shutdown; ports always accessible.
// - Clearing the run bit enters shutdown; shutdown whenever the bit is zero.
// - Shutdown ends when run bit is set by write or chip-select pulse wake.
// - Registers stay accessible in shutdown; shutdown alters no stored value.
// - On leaving shutdown, current ports resume at once with stored codes.
// - Logic code changed to sink code in shutdown turns off, sinks on run.
// - Sink code changed to logic code in shutdown takes that level at once.
// - With wake enabled, chip-select low for 256 PWM clocks sets run bit.

package lgp_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NPORTS = 10;
	localparam int IDX_W  = 4;
	localparam int CODE_W = 8;

	// ------------------------------------------------------------
	// Output register codes
	// ------------------------------------------------------------
	localparam logic [CODE_W-1:0] CODE_LOW     = 8'h00;
	localparam logic [CODE_W-1:0] CODE_HIGH    = 8'h01;
	localparam logic [CODE_W-1:0] CODE_STATIC  = 8'h02;
	localparam logic [CODE_W-1:0] CODE_PWM_MIN = 8'h03;
	localparam logic [CODE_W-1:0] CODE_PWM_MAX = 8'hFE;
	localparam logic [CODE_W-1:0] CODE_OFF     = 8'hFF;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [CODE_W-1:0] CODE_RST  = CODE_OFF;
	localparam logic              RUN_RST   = 1'b0;
	localparam logic              WAKE_RST  = 1'b0;
	localparam logic              HALF_RST  = 1'b0;
	localparam int                CS_WAKE_PERIODS = 256;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic                  code_wr;
		logic [IDX_W-1:0]      port;
		logic [CODE_W-1:0]     code;
		logic                  half_wr;
		logic                  half;
		logic                  cfg_wr;
		logic                  run;
		logic                  cs_wake_en;
	} lgp_host_t;

	typedef struct packed {
		logic [NPORTS-1:0][CODE_W-1:0] code;
		logic [NPORTS-1:0]             half;
		logic [NPORTS-1:0]             port_in;
		logic                          run;
		logic                          cs_wake_en;
		logic                          standby;
		logic                          pwm_running;
	} lgp_stat_t;

	typedef struct packed {
		logic [NPORTS-1:0] pin_out;
		logic [NPORTS-1:0] pin_oe;
		logic [NPORTS-1:0] mirror_en;
		logic [NPORTS-1:0] full_current;
	} lgp_drive_t;

endpackage

// file: lgp_port_ctrl.sv
// Port control logic: output codes, run bit, PWM counter, chip-select wake.
// Expects the host command struct on mclk; pins and PWM clock are asynchronous.
`timescale 1ns/10ps

module lgp_port_ctrl #(
	parameter int CS_WAKE_COUNT = lgp_pkg::CS_WAKE_PERIODS
) (
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire lgp_pkg::lgp_host_t            host,
	input  wire logic                          cs_n_pin,
	input  wire logic                          pwm_clk_pin,
	input  wire logic [lgp_pkg::NPORTS-1:0]    io_port_pins_in,
	output lgp_pkg::lgp_drive_t                drive,
	output lgp_pkg::lgp_stat_t                 stat
);

	localparam int N    = lgp_pkg::NPORTS;
	localparam int CW   = lgp_pkg::CODE_W;
	localparam int CS_W = $clog2(CS_WAKE_COUNT + 1);
	localparam logic [CS_W-1:0] CS_LAST = CS_W'(CS_WAKE_COUNT - 1);
	localparam int IW   = lgp_pkg::IDX_W;
	localparam logic [IW-1:0]   N_IDX   = IW'(N);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [N-1:0][CW-1:0] code_reg;
		logic [N-1:0]         half_reg;
		logic                 run_reg;
		logic                 wake_en_reg;
		logic [1:0]           pwm_sync_reg;
		logic                 pwm_prev_reg;
		logic [1:0]           cs_sync_reg;
		logic [N-1:0]         in_sync1_reg;
		logic [N-1:0]         in_sync2_reg;
		logic [CW-1:0]        pwm_cnt_reg;
		logic [CS_W-1:0]      cs_cnt_reg;
		logic [N-1:0]         oe_reg;
		logic [N-1:0]         mirror_reg;
	} lgp_state_t;

	lgp_state_t st_reg;
	lgp_state_t st_next;

	// ------------------------------------------------------------
	// Code classes
	// ------------------------------------------------------------
	function automatic logic lgp_is_pwm(input logic [CW-1:0] c);
		lgp_is_pwm = (c >= lgp_pkg::CODE_PWM_MIN) && (c <= lgp_pkg::CODE_PWM_MAX);
	endfunction

	function automatic logic lgp_is_sink(input logic [CW-1:0] c);
		lgp_is_sink = (c == lgp_pkg::CODE_STATIC) || lgp_is_pwm(c);
	endfunction

	logic         pwm_tick;
	logic         any_pwm;
	logic         any_sink;
	logic         cs_low;
	logic         wake_fire;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;

		// Only the second flop of each synchroniser feeds logic
		st_next.pwm_sync_reg = {st_reg.pwm_sync_reg[0], pwm_clk_pin};
		st_next.pwm_prev_reg = st_reg.pwm_sync_reg[1];
		st_next.cs_sync_reg  = {st_reg.cs_sync_reg[0], cs_n_pin};
		st_next.in_sync1_reg = io_port_pins_in;
		st_next.in_sync2_reg = st_reg.in_sync1_reg;

		pwm_tick = st_reg.pwm_sync_reg[1] & ~st_reg.pwm_prev_reg;
		cs_low   = ~st_reg.cs_sync_reg[1];

		any_pwm  = 1'b0;
		any_sink = 1'b0;
		for (int i = 0; i < N; i++) begin
			any_pwm  = any_pwm | lgp_is_pwm(st_reg.code_reg[i]);
			any_sink = any_sink | lgp_is_sink(st_reg.code_reg[i]);
		end

		// Counter is held at zero in standby so the PWM logic stays idle
		if (any_pwm) begin
			st_next.pwm_cnt_reg = st_reg.pwm_cnt_reg + (pwm_tick ? 8'h01 : 8'h00);
		end else begin
			st_next.pwm_cnt_reg = '0;
		end

		// Wake counter ignores serial clock and data entirely
		wake_fire = 1'b0;
		if (!cs_low || !st_reg.wake_en_reg) begin
			st_next.cs_cnt_reg = '0;
		end else if (pwm_tick && (st_reg.cs_cnt_reg <= CS_LAST)) begin
			st_next.cs_cnt_reg = st_reg.cs_cnt_reg + CS_W'(1);
			wake_fire = (st_reg.cs_cnt_reg == CS_LAST);
		end

		// Writes are accepted whatever the run bit says
		if (host.code_wr && (host.port < N_IDX)) begin
			st_next.code_reg[host.port] = host.code;
		end
		if (host.half_wr && (host.port < N_IDX)) begin
			st_next.half_reg[host.port] = host.half;
		end
		if (host.cfg_wr) begin
			st_next.run_reg     = host.run;
			st_next.wake_en_reg = host.cs_wake_en;
		end
		// Wake is applied after any coincident write, so a set is never lost
		if (wake_fire) begin
			st_next.run_reg = 1'b1;
		end

		// Port drive from the stored codes; shutdown gates only the sinks
		for (int i = 0; i < N; i++) begin
			unique case (1'b1)
				(st_reg.code_reg[i] == lgp_pkg::CODE_LOW): begin
					st_next.oe_reg[i]     = 1'b1;
					st_next.mirror_reg[i] = 1'b0;
				end
				(st_reg.code_reg[i] == lgp_pkg::CODE_STATIC): begin
					st_next.oe_reg[i]     = st_reg.run_reg;
					st_next.mirror_reg[i] = st_reg.run_reg;
				end
				lgp_is_pwm(st_reg.code_reg[i]): begin
					st_next.oe_reg[i]     = st_reg.run_reg
						& (st_reg.pwm_cnt_reg < st_reg.code_reg[i]);
					st_next.mirror_reg[i] = st_reg.run_reg
						& (st_reg.pwm_cnt_reg < st_reg.code_reg[i]);
				end
				default: begin
					// Logic high and LED off are both released by the open drain
					st_next.oe_reg[i]     = 1'b0;
					st_next.mirror_reg[i] = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg              <= '0;
			st_reg.code_reg     <= {N{lgp_pkg::CODE_RST}};
			st_reg.half_reg     <= {N{lgp_pkg::HALF_RST}};
			st_reg.run_reg      <= lgp_pkg::RUN_RST;
			st_reg.wake_en_reg  <= lgp_pkg::WAKE_RST;
			st_reg.pwm_sync_reg <= '0;
			st_reg.cs_sync_reg  <= 2'h3;
			st_reg.oe_reg       <= '0;
			st_reg.mirror_reg   <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Open-drain pins only ever pull low
	assign drive.pin_out      = '0;
	assign drive.pin_oe       = st_reg.oe_reg;
	assign drive.mirror_en    = st_reg.mirror_reg;
	assign drive.full_current = ~st_reg.half_reg;

	assign stat.code        = st_reg.code_reg;
	assign stat.half        = st_reg.half_reg;
	assign stat.port_in     = st_reg.in_sync2_reg;
	assign stat.run         = st_reg.run_reg;
	assign stat.cs_wake_en  = st_reg.wake_en_reg;
	assign stat.standby     = ~any_sink;
	assign stat.pwm_running = any_pwm;

endmodule

// file: lgp_port_ctrl_props.sv
// Concurrent checks on the port control block, bound to its ports.
// Assumes one mclk domain with synchronous active-high rst.
`timescale 1ns/10ps

module lgp_port_ctrl_props (
	input wire logic                mclk,
	input wire logic                rst,
	input wire lgp_pkg::lgp_host_t  host,
	input wire lgp_pkg::lgp_drive_t drive,
	input wire lgp_pkg::lgp_stat_t  stat
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	pin_low_only_a: assert property (drive.pin_out == '0)
		else $error("pin_out driven high");
	reset_released_a: assert property ($fell(rst) |-> drive.pin_oe == '0)
		else $error("port driven after reset");
	static_sink_a: assert property (stat.run && stat.code[0] == 8'h02 |=> drive.mirror_en[0])
		else $error("static sink not on");
	off_released_a: assert property (stat.code[2] == 8'hFF |=> !drive.pin_oe[2])
		else $error("off port driven");
	mirror_gated_a: assert property ((drive.mirror_en & ~drive.pin_oe) == '0)
		else $error("mirror on while port idle");
	shutdown_off_a: assert property (!stat.run |=> drive.mirror_en == '0)
		else $error("sink active in shutdown");
	logic_low_a: assert property (stat.code[1] == 8'h00 |=> drive.pin_oe[1] && !drive.mirror_en[1])
		else $error("logic low port wrong");
	standby_pwm_a: assert property (stat.standby |-> !stat.pwm_running)
		else $error("pwm running in standby");
	run_write_a: assert property (host.cfg_wr && host.run |=> stat.run)
		else $error("run bit not set");
	stop_write_a: assert property (host.cfg_wr && !host.run && !stat.cs_wake_en |=> !stat.run)
		else $error("run bit not cleared");
	codes_held_a: assert property (!host.code_wr |=> $stable(stat.code))
		else $error("code changed without write");
endmodule

bind lgp_port_ctrl lgp_port_ctrl_props i_props (.mclk(mclk), .rst(rst), .host(host),
	.drive(drive), .stat(stat));

// file: lgp_board_model.sv
// Board around the ports: pull-ups, external input sources, PWM oscillator.
// Assumes open-drain ports; a released pin reads high unless a source pulls it low.
`timescale 1ns/10ps

module lgp_board_model (
	input  wire logic [9:0] oe,
	input  wire logic [9:0] ext_low,
	output logic            pwm_clk,
	output logic [9:0]      pins
);
	// Oscillator runs free, eight mclk periods, well inside the sampling limit
	assign pins = ~(oe | ext_low);
	initial begin
		pwm_clk = 1'b0;
		forever #40 pwm_clk = ~pwm_clk;
	end
endmodule

// file: lgp_port_ctrl_tb.sv
// Self-checking bench for the port control block.
// Assumes the board model for pins and PWM clock; bench acts as host.
`timescale 1ns/10ps

module lgp_port_ctrl_tb;
	logic                mclk, rst, cs_n, pwm_clk;
	logic [9:0]          ext_low, pins;
	lgp_pkg::lgp_host_t  host;
	lgp_pkg::lgp_drive_t drive;
	lgp_pkg::lgp_stat_t  stat;
	int                  err_count = 0;
	int                  comparisons = 0;
	int                  n;

	// Short wake count keeps the run brief
	lgp_port_ctrl #(.CS_WAKE_COUNT(4)) i_lgp_port_ctrl (.mclk(mclk), .rst(rst), .host(host),
		.cs_n_pin(cs_n), .pwm_clk_pin(pwm_clk), .io_port_pins_in(pins), .drive(drive),
		.stat(stat));
	lgp_board_model i_lgp_board_model (.oe(drive.pin_oe), .ext_low(ext_low),
		.pwm_clk(pwm_clk), .pins(pins));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic settle(int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	task automatic put(lgp_pkg::lgp_host_t h);
		@(posedge mclk);
		host <= h;
		@(posedge mclk);
		host <= '0;
	endtask

	task automatic wr(logic [3:0] p, logic [7:0] c);
		put(lgp_pkg::lgp_host_t'{code_wr: 1'b1, port: p, code: c, default: '0});
	endtask

	task automatic cfg(logic r, logic w);
		put(lgp_pkg::lgp_host_t'{cfg_wr: 1'b1, run: r, cs_wake_en: w, default: '0});
		settle(2);
	endtask

	initial begin
		rst = 1'b1;
		host = '0;
		cs_n = 1'b1;
		ext_low = '0;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		settle(1);
		for (int i = 0; i < 10; i++) chk("code_rst", {4'h0, stat.code[i]}, 12'h0FF);
		chk("oe_rst", {2'h0, drive.pin_oe}, 12'h000);
		chk("pin_out", {2'h0, drive.pin_out}, 12'h000);
		chk("full_rst", {2'h0, drive.full_current}, 12'h3FF);
		chk("stat_rst", {9'h0, stat.run, stat.standby, stat.pwm_running}, 12'h002);
		wr(0, 8'h00);
		wr(0, 8'h02);
		wr(1, 8'h00);
		wr(3, 8'h80);
		settle(2);
		chk("oe_shut", {2'h0, drive.pin_oe}, 12'h002);
		chk("pwm_on", {11'h0, stat.pwm_running}, 12'h001);
		cfg(1'b1, 1'b0);
		chk("oe_run", {2'h0, drive.pin_oe & 10'h3F7}, 12'h003);
		chk("mirror_run", {2'h0, drive.mirror_en & 10'h3F7}, 12'h001);
		n = 0;
		repeat (2048) begin
			settle(1);
			n += int'(drive.mirror_en[3]);
		end
		chk("duty", n[11:0], 12'h400);
		put(lgp_pkg::lgp_host_t'{half_wr: 1'b1, port: 4'h0, half: 1'b1, default: '0});
		settle(2);
		chk("full", {2'h0, drive.full_current}, 12'h3FE);
		chk("half", {2'h0, stat.half}, 12'h001);
		ext_low <= 10'h004;
		settle(4);
		chk("port_in", {2'h0, stat.port_in & 10'h3F4}, 12'h3F0);
		cfg(1'b0, 1'b0);
		chk("oe_off", {2'h0, drive.pin_oe}, 12'h002);
		chk("code_kept", {4'h0, stat.code[0]}, 12'h002);
		wr(3, 8'h00);
		settle(2);
		chk("oe_gpio", {2'h0, drive.pin_oe}, 12'h00A);
		cfg(1'b0, 1'b1);
		chk("wake_en", {11'h0, stat.cs_wake_en}, 12'h001);
		@(posedge mclk);
		cs_n <= 1'b0;
		repeat (16) @(posedge mclk);
		cs_n <= 1'b1;
		settle(4);
		chk("short_cs", {11'h0, stat.run}, 12'h000);
		@(posedge mclk);
		cs_n <= 1'b0;
		for (n = 0; n < 200 && stat.run !== 1'b1; n++) settle(1);
		chk("wake", {11'h0, stat.run}, 12'h001);
		if (stat.run === 1'b1) begin
			@(posedge mclk);
			cs_n <= 1'b1;
			settle(2);
			chk("oe_wake", {2'h0, drive.pin_oe}, 12'h00B);
			for (int i = 0; i < 10; i++) wr(i[3:0], 8'h01);
			// Out-of-range index must not land anywhere, or standby would drop
			wr(4'hF, 8'h02);
			settle(2);
			chk("standby", {10'h0, stat.standby, stat.pwm_running}, 12'h002);
		end
		end_sim();
	end
endmodule
